//--- hw/rtd_pin_map.svh
`ifndef RTD_PIN_MAP_SVH
`define RTD_PIN_MAP_SVH

// pin count: port a 0..14, port b 15..30, port c 31..39
`define RTD_NPIN          40
// pins of port b 0..5, kept out of both free matrices
`define RTD_EXCL_LO       15
`define RTD_EXCL_HI       20
// free matrix code ranges
`define RTD_OUT_CODE_MAX  94
`define RTD_IN_CODE_MAX   34
`define RTD_CODE_W        7
`define RTD_IN_CODE_W     6
// fixed alternate functions
`define RTD_FIX_SEL_W     2
`define RTD_FIX_COUNT     69
// field layout of a fixed-table row (four codes)
`define RTD_ROW_W         28
// idle level of free inputs, bit n = code n (serial rx, cts, selects idle high)
`define RTD_FIN_IDLE      35'h082BC0000
// reset values
`define RTD_OE_RST        40'h00000000_00
`define RTD_OUT_RST       40'h00000000_00
// synchroniser depth on pad inputs
`define RTD_SYNC_STAGES   2

`endif

//--- hw/rtd_pkg.sv
package rtd_pkg;

  // fixed alternate function codes, 0 means nothing attached
  typedef enum logic [6:0] {
    F_NONE = 7'h00,
    F_PD0, F_PD1, F_PD2, F_PD3, F_PD4, F_PD5, F_PD6, F_PD7,
    F_PD8, F_PD9, F_PD10, F_PD11, F_PD12, F_PD13, F_PD14, F_PD15,
    F_PD16, F_PD17, F_PD18, F_PD19, F_PD20, F_PD21, F_PD22, F_PD23,
    F_PTE,
    F_RXD0, F_RXD1, F_RXD2, F_RXD3, F_REFCLK, F_TXD0, F_TXD1, F_TXEN, F_CRSDV, F_RXER,
    F_QIO0, F_QIO1, F_QIO2, F_QIO3, F_QCLK,
    F_OIO0, F_OIO1, F_OIO2, F_OIO3, F_OCLK, F_OSEL0,
    F_CD0, F_CD1, F_CD2, F_CD3, F_CCLK, F_CCMD,
    F_CVS, F_CHS, F_CAM0, F_CAM1, F_CAM2, F_CAM3, F_CAM4, F_CAM5, F_CAM6, F_CAM7,
    F_CMCLK, F_CPCLK,
    F_PDOT, F_PVS, F_PHS, F_PDE
  } rtd_fix_e;

  // per-pin configuration from the gpio control registers
  typedef struct packed {
    logic       fixed_en;   // pin owned by a fixed alternate function
    logic [1:0] fixed_sel;  // which of the four
    logic [6:0] out_code;   // free output code, 0 or >94 = gpio
    logic [5:0] in_code;    // free input code, 0 or >34 = none
  } rtd_pin_cfg_t;

  // free output sources; field bit k carries code (field base + k)
  typedef struct packed {
    logic [23:0] panel_pixel;          // 71..94
    logic [3:0]  panel_ctl;            // 67..70
    logic        clock_pin_export;     // 66
    logic [7:0]  audio;                // 58..65
    logic [17:0] spi;                  // 40..57
    logic        quad_memory_select1;  // 39
    logic        microphone_clock_out; // 38
    logic [5:0]  card;                 // 32..37
    logic [3:0]  lamp_pwm;             // 28..31
    logic [3:0]  basic_pwm;            // 24..27, timer 3 first
    logic [5:0]  simple_pwm;           // 18..23, timer 5 first
    logic [4:0]  serial;               // 13..17
    logic [9:0]  radio;                // 3..12
    logic [1:0]  comparator;           // 1..2
    logic        unused0;              // code 0, never routed
  } rtd_fout_t;

endpackage

//--- hw/rtd_sync.sv
`timescale 1ns/10ps
module rtd_sync #(
  parameter int W      = 1,
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // asynchronous level in, synchronised level out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  // a single stage would pass metastability on
  if (STAGES < 2) begin : g_bad
    $error("rtd_sync needs at least two stages");
  end

  logic [W-1:0] stage_q [STAGES];  // chain; stage 0 read only by stage 1

  ////////////////////////////////////////////////////////////////////////////
  // flop chain
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int s = 0; s < STAGES; s++) begin
        stage_q[s] <= '0;
      end
    end else begin
      stage_q[0] <= async_i;
      for (int s = 1; s < STAGES; s++) begin
        stage_q[s] <= stage_q[s-1];
      end
    end
  end

  assign sync_o = stage_q[STAGES-1];

endmodule

//--- hw/rtd_router.sv
`timescale 1ns/10ps
`include "rtd_pin_map.svh"
module rtd_router #(
  parameter int NPIN = `RTD_NPIN
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // pin configuration
  input  wire rtd_pkg::rtd_pin_cfg_t [NPIN-1:0] pin_cfg,
  // plain gpio controller
  input  wire logic [NPIN-1:0]            gpio_out,
  input  wire logic [NPIN-1:0]            gpio_oe,
  output logic      [NPIN-1:0]            gpio_in_q,
  // fixed alternate function peripherals, bit n = function code n
  input  wire logic [`RTD_FIX_COUNT-1:1]  fixed_out,
  input  wire logic [`RTD_FIX_COUNT-1:1]  fixed_oe,
  output logic      [`RTD_FIX_COUNT-1:1]  fixed_in_q,
  // free output matrix sources
  input  wire rtd_pkg::rtd_fout_t         fout_val,
  input  wire rtd_pkg::rtd_fout_t         fout_oe,
  // free input matrix destinations, free_in_q bit n = input code n
  output logic [`RTD_IN_CODE_MAX:1]       free_in_q,
  output logic [12:0]                     panel_in_q,
  output logic                            panel_tearing_in_q,
  // pads
  input  wire logic [NPIN-1:0]            pin_in,
  output logic      [NPIN-1:0]            pin_out_q,
  output logic      [NPIN-1:0]            pin_oe_q
);
  import rtd_pkg::*;

  // the fixed table below is written for exactly this pin count
  if (NPIN != `RTD_NPIN) begin : g_bad
    $error("rtd_router serves exactly forty pins");
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoding functions

  // port b 0..5 sit in their own supply domain with no matrix wiring
  function automatic logic rtd_excluded(input int p);
    return (p >= `RTD_EXCL_LO) && (p <= `RTD_EXCL_HI);
  endfunction

  // fixed alternate function of a pin, row packs {f3,f2,f1,f0}
  function automatic logic [6:0] rtd_fixed_code(input int p, input logic [1:0] sel);
    logic [`RTD_ROW_W-1:0] row;
    row = '0;
    case (p)
      0:  row = {F_PD15, F_RXD1, F_PTE, F_PD5};
      1:  row = {F_PD16, F_REFCLK, F_PTE, F_PD6};
      2:  row = {F_NONE, F_OIO0, F_QIO0, F_PD7};
      3:  row = {F_OIO1, F_OIO3, F_QIO3, F_QIO1};
      4:  row = {F_PD17, F_TXD0, F_RXD2, F_PD8};
      5:  row = {F_PD18, F_TXD1, F_RXD3, F_PD9};
      6:  row = {F_PD19, F_TXEN, F_NONE, F_PD10};
      7:  row = {F_CRSDV, F_OSEL0, F_NONE, F_PD11};
      8:  row = {F_RXER, F_OCLK, F_QCLK, F_CD0};
      9:  row = {F_NONE, F_OIO2, F_QIO2, F_CCLK};
      10: row = {F_NONE, F_OIO1, F_QIO1, F_CCMD};
      11: row = {F_NONE, F_OIO2, F_QIO2, F_PD12};
      12: row = {F_PD20, F_OIO1, F_QIO1, F_PD13};
      13: row = {F_PD21, F_OIO0, F_QIO0, F_PD14};
      14: row = {F_PD23, F_OIO3, F_QIO3, F_PD15};
      15: row = {F_NONE, F_NONE, F_CD1, F_NONE};
      16: row = {F_NONE, F_NONE, F_CD0, F_NONE};
      17: row = {F_NONE, F_NONE, F_CCLK, F_NONE};
      18: row = {F_NONE, F_NONE, F_CCMD, F_NONE};
      19: row = {F_NONE, F_NONE, F_CD3, F_NONE};
      20: row = {F_PD23, F_NONE, F_CD2, F_NONE};
      21: row = {F_PD8, F_PD0, F_CVS, F_CD1};
      22: row = {F_PD9, F_PD1, F_CHS, F_CD0};
      23: row = {F_PD10, F_PD2, F_CAM7, F_CCLK};
      24: row = {F_PD11, F_PD3, F_CMCLK, F_CCMD};
      25: row = {F_PD12, F_PD4, F_CAM6, F_CD3};
      26: row = {F_PD13, F_PD5, F_CAM5, F_CD2};
      27: row = {F_PD14, F_PD6, F_CPCLK, F_RXD0};
      28: row = {F_PD15, F_PD7, F_CAM4, F_RXD1};
      29: row = {F_PD16, F_PDOT, F_CAM0, F_REFCLK};
      30: row = {F_PD17, F_PHS, F_CAM3, F_TXD0};
      31: row = {F_PD18, F_PVS, F_CAM1, F_TXD1};
      32: row = {F_PD19, F_PDE, F_CAM2, F_TXEN};
      33: row = {F_PD20, F_PD8, F_NONE, F_CRSDV};
      34: row = {F_PD21, F_PD9, F_NONE, F_RXER};
      35: row = {F_PD22, F_PD10, F_NONE, F_RXD2};
      36: row = {F_PD23, F_PD11, F_NONE, F_RXD3};
      39: row = {F_QIO3, F_RXD0, F_OIO3, F_PD0};
      default: row = '0;  // port c 6 and 7 carry no fixed function
    endcase
    return row[sel*7 +: 7];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [NPIN-1:0]             pin_s;       // synchronised pad levels
  logic [`RTD_OUT_CODE_MAX:0]  fval_flat;   // free sources by code
  logic [`RTD_OUT_CODE_MAX:0]  foe_flat;    // free enables by code
  logic [NPIN-1:0]             pin_out_d;   // next pad value
  logic [NPIN-1:0]             pin_oe_d;    // next pad enable
  logic [`RTD_IN_CODE_MAX:1]   free_in_d;   // next free inputs
  logic [`RTD_FIX_COUNT-1:1]   fixed_in_d;  // next fixed inputs
  logic [12:0]                 panel_in_d;  // next panel data inputs

  // idle pattern at its full width, bit n = input code n; bit 0 is never used
  localparam logic [`RTD_IN_CODE_MAX:0] FIN_IDLE = `RTD_FIN_IDLE;

  // struct bit k is code k by construction of the field order
  assign fval_flat = fout_val;
  assign foe_flat  = fout_oe;

  ////////////////////////////////////////////////////////////////////////////
  // pad input synchroniser, pads are outside the clock domain
  rtd_sync #(
    .W      (NPIN),
    .STAGES (`RTD_SYNC_STAGES)
  ) u_sync (
    .clk     (clk),
    .rstn    (rstn),
    .async_i (pin_in),
    .sync_o  (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output selection: fixed function, then free matrix, then gpio
  always_comb begin
    logic [6:0] fc;
    logic [6:0] oc;
    fc = '0;
    oc = '0;
    pin_out_d = gpio_out;
    pin_oe_d  = gpio_oe;
    for (int p = 0; p < NPIN; p++) begin
      oc = pin_cfg[p].out_code;
      if (pin_cfg[p].fixed_en) begin
        // empty table slot leaves the pad undriven
        fc = rtd_fixed_code(p, pin_cfg[p].fixed_sel);
        pin_out_d[p] = (fc != '0) ? fixed_out[fc] : 1'b0;
        pin_oe_d[p]  = (fc != '0) ? fixed_oe[fc] : 1'b0;
      end else if (!rtd_excluded(p) && (oc != '0) &&
                   (oc <= 7'(`RTD_OUT_CODE_MAX))) begin
        pin_out_d[p] = fval_flat[oc];
        pin_oe_d[p]  = foe_flat[oc];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input selection; walking down lets the lowest pin overwrite last
  always_comb begin
    logic [5:0] ic;
    logic [6:0] fc;
    ic = '0;
    fc = '0;
    free_in_d  = FIN_IDLE[`RTD_IN_CODE_MAX:1];
    fixed_in_d = '0;
    for (int p = NPIN - 1; p >= 0; p--) begin
      ic = pin_cfg[p].in_code;
      if (pin_cfg[p].fixed_en) begin
        fc = rtd_fixed_code(p, pin_cfg[p].fixed_sel);
        if (fc != '0) begin
          fixed_in_d[fc] = pin_s[p];
        end
      end else if (!rtd_excluded(p) && (ic != '0) &&
                   (ic <= 6'(`RTD_IN_CODE_MAX))) begin
        free_in_d[ic] = pin_s[p];
      end
    end
  end

  // shared codes fan out to panel data bits 12..0 (bits 1 and 2 unreachable)
  always_comb begin
    panel_in_d = {free_in_d[34], free_in_d[31],
                  free_in_d[21], free_in_d[20],
                  free_in_d[16], free_in_d[15],
                  free_in_d[13], free_in_d[12],
                  free_in_d[11], free_in_d[10],
                  2'b00, free_in_d[24]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_out_q <= `RTD_OUT_RST;
      pin_oe_q  <= `RTD_OE_RST;  // all pads released during reset
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input destination registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gpio_in_q          <= '0;
      fixed_in_q         <= '0;
      free_in_q          <= FIN_IDLE[`RTD_IN_CODE_MAX:1];
      panel_in_q         <= '0;
      panel_tearing_in_q <= 1'b0;
    end else begin
      gpio_in_q          <= pin_s;  // gpio always sees the pad
      fixed_in_q         <= fixed_in_d;
      free_in_q          <= free_in_d;
      panel_in_q         <= panel_in_d;
      panel_tearing_in_q <= free_in_d[17];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // reset seen one edge late; a release made at an edge would otherwise
  // start a check against flops that were still held at that edge
  logic run_q;
  always_ff @(posedge clk) begin
    run_q <= rstn;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !run_q);

  // pins 0 and 1 both ask for serial 0 receive in the same cycle
  sequence both_pick_rx_s;
    !pin_cfg[0].fixed_en && !pin_cfg[1].fixed_en ##0
    pin_cfg[0].in_code == 6'h12 && pin_cfg[1].in_code == 6'h12;
  endsequence

  fixsel_a: assert property (
    pin_cfg[0].fixed_en && pin_cfg[0].fixed_sel == 2'h0
    |=> pin_out_q[0] == $past(fixed_out[F_PD5]) && pin_oe_q[0] == $past(fixed_oe[F_PD5]))
    else $error("pin 0 fixed function 0 not routed");
  excl_pin_a: assert property (
    !pin_cfg[15].fixed_en |=> pin_oe_q[15] == $past(gpio_oe[15]))
    else $error("excluded pin took a matrix function");
  comp_route_a: assert property (
    !pin_cfg[13].fixed_en && pin_cfg[13].out_code == 7'h02
    |=> pin_out_q[13] == $past(fout_val.comparator[1]))
    else $error("comparator 1 not on pin");
  pwm_route_a: assert property (
    !pin_cfg[13].fixed_en && pin_cfg[13].out_code == 7'h12
    |=> pin_out_q[13] == $past(fout_val.simple_pwm[0]))
    else $error("simple timer 5 pwm not on code 18");
  card_route_a: assert property (
    !pin_cfg[13].fixed_en && pin_cfg[13].out_code == 7'h20
    |=> pin_oe_q[13] == $past(fout_oe.card[0]))
    else $error("card clock enable not routed");
  spi_route_a: assert property (
    !pin_cfg[21].fixed_en && pin_cfg[21].out_code == 7'h2F
    |=> pin_out_q[21] == $past(fout_val.spi[7]))
    else $error("spi 1 clock not on code 47");
  pixel_route_a: assert property (
    !pin_cfg[13].fixed_en && pin_cfg[13].out_code == 7'h5E
    |=> pin_out_q[13] == $past(fout_val.panel_pixel[23]))
    else $error("pixel bit 23 not on code 94");
  gpio_fallback_a: assert property (
    !pin_cfg[5].fixed_en && pin_cfg[5].out_code > 7'h5E
    |=> pin_out_q[5] == $past(gpio_out[5]) && pin_oe_q[5] == $past(gpio_oe[5]))
    else $error("out of range code did not fall back to gpio");
  lowest_pin_a: assert property (
    both_pick_rx_s |=> free_in_q[18] == $past(pin_s[0]))
    else $error("lower pin did not win the input");
  // pin 0 is always the lowest selector, so it must reach both destinations
  dual_fanout_a: assert property (
    !pin_cfg[0].fixed_en && pin_cfg[0].in_code == 6'h0D
    |=> panel_in_q[6] == $past(pin_s[0]) && free_in_q[13] == $past(pin_s[0]))
    else $error("capture and panel bit disagree");

  // radio, serial and memory select sources on an odd pin
  radio_route_a: assert property (
    !pin_cfg[21].fixed_en && pin_cfg[21].out_code == 7'h09
    |=> pin_out_q[21] == $past(fout_val.radio[6]))
    else $error("amplifier enable not on code 9");
  serial_route_a: assert property (
    !pin_cfg[21].fixed_en && pin_cfg[21].out_code == 7'h0D
    |=> pin_oe_q[21] == $past(fout_oe.serial[0]))
    else $error("serial 4 transmit enable not on code 13");
  memsel_route_a: assert property (
    !pin_cfg[21].fixed_en && pin_cfg[21].out_code == 7'h27
    |=> pin_out_q[21] == $past(fout_val.quad_memory_select1))
    else $error("memory select 1 not on code 39");

  // audio, clock export and panel control sources on an odd pin, pin 13
  audio_route_a: assert property (
    !pin_cfg[13].fixed_en && pin_cfg[13].out_code == 7'h3E
    |=> pin_out_q[13] == $past(fout_val.audio[4]))
    else $error("audio 1 master clock not on code 62");
  clk_export_a: assert property (
    !pin_cfg[13].fixed_en && pin_cfg[13].out_code == 7'h42
    |=> pin_out_q[13] == $past(fout_val.clock_pin_export))
    else $error("clock export not on code 66");
  panel_ctl_a: assert property (
    !pin_cfg[13].fixed_en && pin_cfg[13].out_code == 7'h44
    |=> pin_out_q[13] == $past(fout_val.panel_ctl[1]))
    else $error("panel select line not on code 68");

  // input destinations fed from pin 0, which no other pin can outrank
  capture_in_a: assert property (
    !pin_cfg[0].fixed_en && pin_cfg[0].in_code == 6'h02
    |=> free_in_q[2] == $past(pin_s[0]))
    else $error("timer sync input not fed");
  coexist_in_a: assert property (
    !pin_cfg[0].fixed_en && pin_cfg[0].in_code == 6'h07
    |=> free_in_q[7] == $past(pin_s[0]))
    else $error("coexist request input not fed");
  tearing_in_a: assert property (
    !pin_cfg[0].fixed_en && pin_cfg[0].in_code == 6'h11
    |=> panel_tearing_in_q == $past(pin_s[0]))
    else $error("panel tearing input not fed");
  serial_in_a: assert property (
    !pin_cfg[0].fixed_en && pin_cfg[0].in_code == 6'h14
    |=> panel_in_q[9] == $past(pin_s[0]) && free_in_q[20] == $past(pin_s[0]))
    else $error("serial 1 receive or panel bit 9 not fed");
  nmi_in_a: assert property (
    !pin_cfg[0].fixed_en && pin_cfg[0].in_code == 6'h16
    |=> free_in_q[22] == $past(pin_s[0]))
    else $error("feedback input not fed");
  spi_in_a: assert property (
    !pin_cfg[0].fixed_en && pin_cfg[0].in_code == 6'h22
    |=> panel_in_q[12] == $past(pin_s[0]) && free_in_q[34] == $past(pin_s[0]))
    else $error("spi 1 data or panel bit 12 not fed");

endmodule

//--- test/rtd_pad_model.sv
`timescale 1ns/10ps
module rtd_pad_model #(
  parameter int N = 40  // pad count
) (
  // pad drive from the router
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  // level that the board puts on an undriven pad
  input  wire logic [N-1:0] ext_level,
  // resolved wire level back into the router
  output logic      [N-1:0] pin_level
);
  ////////////////////////////////////////////////////////////////////////////
  // resolve each wire: router wins while it drives, the board otherwise;
  // the board level is always a definite value so nothing floats to x
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_level[i] = pad_oe[i] ? pad_out[i] : ext_level[i];
    end
  end
endmodule

//--- test/digital_pin_function_router_tb.sv
`timescale 1ns/10ps
`include "rtd_pin_map.svh"
module digital_pin_function_router_tb;
  import rtd_pkg::*;
  // one output-path case: config of one pin, sources raised, expected pad
  typedef struct {
    int         pin;
    logic       fen;
    logic [1:0] sel;
    logic [6:0] code;
    logic       all;   // raise every source, so any misroute shows as 1
    int         fbit;  // single fixed source raised
    int         vbit;  // single free source raised
    logic       eo;    // x = pad value not looked at
    logic       eoe;
  } rtd_row_t;

  logic                clk;
  logic                rstn;
  rtd_pin_cfg_t [39:0] pin_cfg;
  logic [39:0]         gpio_out, gpio_oe, gpio_in_q, pin_in, pin_out_q, pin_oe_q, ext_level;
  logic [68:1]         fixed_out, fixed_oe, fixed_in_q;
  rtd_fout_t           fout_val, fout_oe;
  logic [34:1]         free_in_q;
  logic [12:0]         panel_in_q;
  logic                panel_tearing_in_q;
  logic [34:0]         idle;   // unselected free input levels
  int                  fails, samples_checked;
  rtd_row_t            rows[$];

  ////////////////////////////////////////////////////////////////////////////
  rtd_router #(.NPIN(40)) uut (
    .clk(clk), .rstn(rstn), .pin_cfg(pin_cfg),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in_q(gpio_in_q),
    .fixed_out(fixed_out), .fixed_oe(fixed_oe), .fixed_in_q(fixed_in_q),
    .fout_val(fout_val), .fout_oe(fout_oe), .free_in_q(free_in_q),
    .panel_in_q(panel_in_q), .panel_tearing_in_q(panel_tearing_in_q),
    .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q)
  );
  rtd_pad_model #(.N(40)) pad (
    .pad_out(pin_out_q), .pad_oe(pin_oe_q), .ext_level(ext_level), .pin_level(pin_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare and count; x never passes
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // one edge to launch, one edge for the registered pad answer
  task automatic drive_row(input rtd_row_t r);
    rtd_pin_cfg_t [39:0] c;
    logic [68:0]         f;
    logic [94:0]         v;
    logic [39:0]         m;
    c = '0;
    c[r.pin] = '{r.fen, r.sel, r.code, 6'h00};
    f = r.all ? '1 : (69'h1 << r.fbit);
    v = r.all ? '1 : (95'h1 << r.vbit);
    m = 40'h1 << r.pin;
    @(posedge clk);
    pin_cfg   <= c;
    fixed_out <= f[68:1];
    fout_val  <= rtd_fout_t'(v);
    fout_oe   <= rtd_fout_t'(v);
    @(posedge clk);
    #1;
    if (r.eo !== 1'bx) check(pin_out_q[r.pin], r.eo);
    check(pin_oe_q[r.pin], r.eoe);
    // untouched pins stay plain gpio
    check(pin_out_q & ~m, gpio_out & ~m);
    check(pin_oe_q & ~m, gpio_oe & ~m);
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rtd_pin_cfg_t [39:0] c;
    logic [34:1]         e;
    logic [68:0]         f;
    fails = 0;
    samples_checked = 0;
    idle = 35'(`RTD_FIN_IDLE);
    rstn = 1'b0;
    pin_cfg = '0;
    gpio_out = 40'h5555555555;   // odd pins low, so gpio fall-through is visible
    gpio_oe = 40'h5555555555;
    fixed_out = '0;
    fixed_oe = '1;
    fout_val = '0;
    fout_oe = rtd_fout_t'({95{1'b1}});
    ext_level = '0;
    // free matrix sweep, odd pins either side of the excluded group
    for (int k = 1; k <= 94; k++) begin
      rows.push_back('{(k % 2) ? 21 : 13, 1'b0, 2'h0, 7'(k), 1'b0, 0, k, 1'b1, 1'b1});
    end
    // fixed alternates of one pin, plus an excluded pin and a far pin
    rows.push_back('{0, 1'b1, 2'h0, 7'h00, 1'b0, int'(F_PD5), 0, 1'b1, 1'b1});
    rows.push_back('{0, 1'b1, 2'h1, 7'h00, 1'b0, int'(F_PTE), 0, 1'b1, 1'b1});
    rows.push_back('{0, 1'b1, 2'h2, 7'h00, 1'b0, int'(F_RXD1), 0, 1'b1, 1'b1});
    rows.push_back('{0, 1'b1, 2'h3, 7'h00, 1'b0, int'(F_PD15), 0, 1'b1, 1'b1});
    rows.push_back('{15, 1'b1, 2'h1, 7'h00, 1'b0, int'(F_CD1), 0, 1'b1, 1'b1});
    rows.push_back('{39, 1'b1, 2'h1, 7'h00, 1'b0, int'(F_OIO3), 0, 1'b1, 1'b1});
    // empty table slot: pad released
    rows.push_back('{2, 1'b1, 2'h3, 7'h00, 1'b1, 0, 0, 1'bx, 1'b0});
    // fixed beats a live free code
    rows.push_back('{0, 1'b1, 2'h0, 7'h01, 1'b0, int'(F_PTE), 1, 1'b0, 1'b1});
    // codes that leave the pin to gpio, excluded pins included
    rows.push_back('{5, 1'b0, 2'h0, 7'h00, 1'b1, 0, 0, 1'b0, 1'b0});
    rows.push_back('{5, 1'b0, 2'h0, 7'h5F, 1'b1, 0, 0, 1'b0, 1'b0});
    rows.push_back('{5, 1'b0, 2'h0, 7'h7F, 1'b1, 0, 0, 1'b0, 1'b0});
    rows.push_back('{15, 1'b0, 2'h0, 7'h05, 1'b1, 0, 0, 1'b0, 1'b0});
    rows.push_back('{19, 1'b0, 2'h0, 7'h5E, 1'b1, 0, 0, 1'b0, 1'b0});
    // reset held five cycles
    repeat (5) @(posedge clk);
    rstn <= 1'b1;  // released at the fifth edge, taken from the sixth
    #1;
    check(pin_oe_q, 40'h0);
    check(free_in_q, idle[34:1]);
    check({panel_in_q, gpio_in_q}, 53'h0);
    foreach (rows[i]) begin
      drive_row(rows[i]);
    end
    // input matrix: two pins on one code, an excluded pin, a fixed pin
    c = '0;
    c[0].in_code = 6'd18;
    c[1].in_code = 6'd18;
    c[4].in_code = 6'd10;
    c[6].in_code = 6'd10;
    c[16].in_code = 6'd2;
    c[7].in_code = 6'd17;
    c[8].in_code = 6'd24;
    c[9] = '{1'b1, 2'h0, 7'h00, 6'd22};
    @(posedge clk);
    pin_cfg <= c;
    gpio_oe <= '0;
    fixed_oe <= '0;
    ext_level <= 40'h0000010392;
    repeat (4) @(posedge clk);
    #1;
    e = idle[34:1];
    e[18] = 1'b0;
    e[10] = 1'b1;
    e[17] = 1'b1;
    e[24] = 1'b1;
    f = 69'h1 << int'(F_CCLK);
    check(free_in_q, e);
    // panel bits 9..11 follow the idle-high codes 20, 21 and 31
    check(panel_in_q, 13'h0E09);
    check(panel_tearing_in_q, 1'b1);
    check(gpio_in_q, 40'h0000010392);
    check(fixed_in_q, f[68:1]);
    // every free input code on pin 0, level opposite to its idle value
    for (int k = 1; k <= 34; k++) begin
      c = '0;
      c[0].in_code = 6'(k);
      @(posedge clk);
      pin_cfg <= c;
      ext_level <= 40'(~idle[k]);
      repeat (4) @(posedge clk);
      #1;
      e = idle[34:1];
      e[k] = ~idle[k];
      check(free_in_q, e);
    end
    // second reset in mid-run drops every pad and input at once
    @(posedge clk);
    rstn <= 1'b0;
    gpio_oe <= '1;
    @(posedge clk);
    #1;
    check(pin_oe_q, 40'h0);
    check(free_in_q, idle[34:1]);
    check(fixed_in_q, 68'h0);
    // release at an edge; the first edge after it takes the gpio enables while synchronised inputs still read zero
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    check(pin_oe_q, 40'hFFFFFFFFFF);
    check(free_in_q, idle[34:1]);
    give_verdict();
  end
endmodule
